// >>> rtl/csb_core.sv
/*
 Control slice of an 8-bit CPU: wait and deep standby, break entry and
 return, stack and index immediate adds, branch on carry clear.
 Assumes opcode and operand arrive with a valid strobe on the same clock,
 and that the break module and interrupt sources are outside.
*/
// Operation
// - The wait instruction clears the mask and stops the core clock; interrupt wake keeps it clear, reset sets it.
// - The deep standby instruction clears the mask and stops the clock; external wake keeps it clear, reset sets it.
// - After deep standby the clock stays stopped until the oscillator delay has run out.
// - An enabled break request lets the current instruction finish, then runs the software trap sequence.
// - The break vector is FFFC in normal operation and FEFC in monitor mode.
// - The return from trap in the break handler ends the break once the request is withdrawn.
// - Opcode A7 adds a sign-extended immediate to the stack pointer in 2 cycles, flags unchanged.
// - Opcode AF adds a sign-extended immediate to the index pair in 2 cycles, flags unchanged.
// - Opcode 24 takes 3 cycles and branches to PC plus 2 plus offset when carry is clear.
// - Maskable interrupts are ignored while the mask is set and accepted while clear.
// - On any interrupt entry the mask is set after stacking, in the same cycle as the vector fetch.
`timescale 1ns/100ps
module csb_core (
   // Clock and reset
   input  wire logic               CLOCK,
   input  wire logic               ARST_N,
   // Instruction stream
   input  wire logic               OP_VALID,
   input  wire logic [7:0]         OPCODE,
   input  wire logic [7:0]         OPERAND,
   input  wire logic               CARRY_IN,
   // Interrupts and break
   input  wire logic               IRQ_REQ,
   input  wire logic               EXT_IRQ,
   input  wire logic               BRK_ENABLE,
   input  wire logic               BRK_REQ,
   input  wire logic               MONITOR_MODE,
   // State out
   output logic                    CPU_CLK_EN,
   output logic                    BUSY,
   output logic                    IMASK,
   output logic                    IN_BREAK,
   output logic                    STACKING,
   output logic                    VEC_FETCH,
   output logic [15:0]             VEC_ADDR,
   output logic [15:0]             PC,
   output logic [15:0]             SP,
   output logic [15:0]             HX
);
   import csb_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Reset release and pin synchronisers
   logic [1:0] rst_sync;
   wire        rst_n = rst_sync[1];
   wire  [2:0] pin_raw = {BRK_REQ, EXT_IRQ, IRQ_REQ};
   wire  [2:0] pin_ok;
   wire        irq_ok  = pin_ok[0];
   wire        ext_ok  = pin_ok[1];
   wire        brk_ok  = pin_ok[2];

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) rst_sync <= 2'h0;
      else         rst_sync <= {rst_sync[0], 1'b1};
   end

   // A level counts only once stages two and three agree; costs one cycle of latency
   for (genvar g = 0; g < 3; g++) begin : g_pin
      logic [2:0] stage;
      logic       level;
      always_ff @(posedge CLOCK or negedge rst_n) begin
         if (!rst_n) begin
            stage <= 3'h0;
            level <= 1'b0;
         end else begin
            stage <= {stage[1:0], pin_raw[g]};
            if (stage[1] == stage[2])
               level <= stage[2];
         end
      end
      assign pin_ok[g] = level;
   end

   ////////////////////////////////////////////////////////////////////////
   // Decode
   function automatic logic [15:0] sext(input logic [7:0] v);
      return {{8{v[7]}}, v};
   endfunction

   csb_state_t     state, next_state;
   logic [2:0]     cyc;
   logic [7:0]     op, opd;
   logic           trap_brk;
   wire            osc_done;
   wire            take_op    = (state == CSB_RUN) && OP_VALID;
   wire            take_brk   = (state == CSB_RUN) && BRK_ENABLE && brk_ok && !IN_BREAK;
   wire            take_irq   = (state == CSB_RUN) && irq_ok && !IMASK;
   wire            is_wait    = take_op && !take_brk && !take_irq && OPCODE == OP_WAIT;
   wire            is_stop    = take_op && !take_brk && !take_irq && OPCODE == OP_STOP;
   wire            ins_end    = (state == CSB_EXEC) && (cyc == CYC_ONE);
   wire            trap_op    = (op == OP_TRAP);
   wire [2:0]      op_cycles  = (OPCODE == OP_ADD_SP || OPCODE == OP_ADD_IX) ? CYC_ADD :
                                (OPCODE == OP_BR_CC) ? CYC_BR :
                                (OPCODE == OP_TRAP) ? CYC_TRAP : CYC_ONE;
   wire [15:0]     brk_vec    = MONITOR_MODE ? VEC_BRK_MON : VEC_BRK_NORMAL;
   wire [15:0]     br_target  = PC + BR_BASE_INC + sext(opd);
   wire            wake_wait  = (state == CSB_WAIT) && (irq_ok || ext_ok || brk_ok);
   wire            wake_stop  = (state == CSB_STOP) && ext_ok;

   always_comb begin
      next_state = state;
      case (state)
         CSB_RUN:  begin
            if (is_wait)                           next_state = CSB_WAIT;
            else if (is_stop)                      next_state = CSB_STOP;
            else if (take_brk || take_irq || take_op) next_state = CSB_EXEC;
         end
         CSB_EXEC: if (cyc == CYC_ONE)             next_state = CSB_RUN;
         CSB_WAIT: if (wake_wait)                  next_state = CSB_RUN;
         CSB_STOP: if (wake_stop)                  next_state = CSB_OSC;
         CSB_OSC:  if (osc_done)                   next_state = CSB_RUN;
         default:                                  next_state = CSB_RUN;
      endcase
   end

   csb_osc_delay u_osc (
      .clk   (CLOCK),
      .rst_n (rst_n),
      .start (wake_stop),
      .done  (osc_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sequencer and architectural state
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         state      <= CSB_RUN;
         cyc        <= 3'h0;
         op         <= 8'h00;
         opd        <= 8'h00;
         trap_brk   <= 1'b0;
         IMASK      <= 1'b1;
         IN_BREAK   <= 1'b0;
         CPU_CLK_EN <= 1'b1;
         BUSY       <= 1'b0;
         STACKING   <= 1'b0;
         VEC_FETCH  <= 1'b0;
         VEC_ADDR   <= 16'h0000;
         PC         <= PC_RESET;
         SP         <= SP_RESET;
         HX         <= IX_RESET;
      end else begin
         state      <= next_state;
         CPU_CLK_EN <= (next_state == CSB_RUN) || (next_state == CSB_EXEC);
         BUSY       <= (next_state == CSB_EXEC);
         STACKING   <= (state == CSB_EXEC) && trap_op && cyc == CYC_TRAP - 3'h1;
         VEC_FETCH  <= 1'b0;
         if (take_brk || take_irq) begin   // Entry only between instructions
            op       <= OP_TRAP;
            trap_brk <= take_brk;
            cyc      <= CYC_TRAP;
         end else if (take_op && !is_wait && !is_stop) begin
            op  <= OPCODE;
            opd <= OPERAND;
            cyc <= op_cycles;
            trap_brk <= 1'b0;
            if (OPCODE == OP_RET_TRAP && IN_BREAK && !brk_ok)
               IN_BREAK <= 1'b0;
         end else if (state == CSB_EXEC) begin
            cyc <= cyc - 3'h1;
         end
         if (is_wait || is_stop)
            IMASK <= 1'b0;
         if (state == CSB_EXEC && trap_op && cyc == CYC_TRAP - 3'h2) begin
            IMASK     <= 1'b1;            // After stacking, with the vector fetch
            VEC_FETCH <= 1'b1;
            VEC_ADDR  <= trap_brk ? brk_vec : VEC_BRK_NORMAL;
            PC        <= trap_brk ? brk_vec : VEC_BRK_NORMAL;
            if (trap_brk)
               IN_BREAK <= 1'b1;
         end
         if (ins_end) begin
            case (op)
               OP_ADD_SP: SP <= SP + sext(opd);
               OP_ADD_IX: HX <= HX + sext(opd);
               OP_BR_CC:  PC <= CARRY_IN ? PC + BR_BASE_INC : br_target;
               default:   ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_add_start;
      take_op && !take_brk && !take_irq && (OPCODE == OP_ADD_SP || OPCODE == OP_ADD_IX);
   endsequence
   sequence s_busy_two;
      BUSY [*2] ##1 !BUSY;
   endsequence
   a_add_two_cycles: assert property (@(posedge CLOCK) disable iff (!rst_n)
      s_add_start |=> s_busy_two) else $error("immediate add not two cycles");
   a_branch_three: assert property (@(posedge CLOCK) disable iff (!rst_n)
      take_op && !take_brk && !take_irq && OPCODE == OP_BR_CC |=> BUSY [*3] ##1 !BUSY)
      else $error("branch not three cycles");
   a_wait_mask: assert property (@(posedge CLOCK) disable iff (!rst_n)
      is_wait |=> !IMASK && !CPU_CLK_EN) else $error("wait did not clear mask");
   a_stop_mask: assert property (@(posedge CLOCK) disable iff (!rst_n)
      is_stop |=> !IMASK && !CPU_CLK_EN) else $error("stop did not clear mask");
   a_osc_hold: assert property (@(posedge CLOCK) disable iff (!rst_n)
      wake_stop |=> !CPU_CLK_EN [*8]) else $error("clock restarted too early");
   a_mask_blocks: assert property (@(posedge CLOCK) disable iff (!rst_n)
      IMASK && !take_brk && !OP_VALID && state == CSB_RUN |=> !BUSY) else $error("masked irq taken");
   a_vec_mask: assert property (@(posedge CLOCK) disable iff (!rst_n)
      VEC_FETCH |-> IMASK && $past(STACKING)) else $error("mask not set at vector fetch");
   a_brk_vector: assert property (@(posedge CLOCK) disable iff (!rst_n)
      VEC_FETCH && $rose(IN_BREAK) |-> VEC_ADDR == (MONITOR_MODE ? 16'hfefc : 16'hfffc))
      else $error("wrong break vector");
   a_brk_entry: assert property (@(posedge CLOCK) disable iff (!rst_n)
      take_brk |=> ##[1:4] IN_BREAK) else $error("break not entered");
   a_brk_exit: assert property (@(posedge CLOCK) disable iff (!rst_n)
      take_op && OPCODE == OP_RET_TRAP && IN_BREAK && !brk_ok && !take_irq |=> !IN_BREAK)
      else $error("break not ended");

   // Cycles spent in the oscillator wait, so the whole hold can be judged
   logic [15:0] osc_seen;
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n)                osc_seen <= 16'h0000;
      else if (state != CSB_OSC) osc_seen <= 16'h0000;
      else                       osc_seen <= osc_seen + 16'h0001;
   end
   a_osc_full_wait: assert property (@(posedge CLOCK) disable iff (!rst_n)
      state == CSB_OSC && osc_done |-> osc_seen >= 16'(OSC_DELAY_CYC))
      else $error("oscillator wait cut short");
endmodule

// >>> rtl/csb_pkg.sv
/*
 Constants for the standby, break and small-instruction control block:
 opcodes, vectors, cycle counts, reset values and the oscillator delay.
 Assumes nothing of its surroundings.
*/
package csb_pkg;
   // Opcodes handled here
   localparam logic [7:0]  OP_ADD_SP      = 8'ha7;
   localparam logic [7:0]  OP_ADD_IX      = 8'haf;
   localparam logic [7:0]  OP_BR_CC       = 8'h24;
   localparam logic [7:0]  OP_WAIT        = 8'h8f;
   localparam logic [7:0]  OP_STOP        = 8'h8e;
   localparam logic [7:0]  OP_TRAP        = 8'h83;
   localparam logic [7:0]  OP_RET_TRAP    = 8'h80;
   // Cycle counts
   localparam logic [2:0]  CYC_ADD        = 3'h2;
   localparam logic [2:0]  CYC_BR         = 3'h3;
   localparam logic [2:0]  CYC_TRAP       = 3'h4;
   localparam logic [2:0]  CYC_ONE        = 3'h1;
   // Vectors and branch base increment
   localparam logic [15:0] VEC_BRK_NORMAL = 16'hfffc;
   localparam logic [15:0] VEC_BRK_MON    = 16'hfefc;
   localparam logic [15:0] BR_BASE_INC    = 16'h0002;
   // Reset values
   localparam logic [15:0] SP_RESET       = 16'h00ff;
   localparam logic [15:0] PC_RESET       = 16'hfffe;
   localparam logic [15:0] IX_RESET       = 16'h0000;
   // Condition flag bit positions
   localparam int          FLAG_C         = 0;
   localparam int          FLAG_I         = 3;
   // Oscillator stabilisation delay
   localparam int          OSC_DELAY_US   = 4;
   localparam int          CLK_MHZ        = 50;
   localparam int          OSC_DELAY_CYC  = OSC_DELAY_US * CLK_MHZ;
   localparam int          OSC_CNT_W      = 8;
   typedef enum {CSB_RUN, CSB_EXEC, CSB_WAIT, CSB_STOP, CSB_OSC} csb_state_t;
endpackage

// >>> rtl/csb_osc_delay.sv
/*
 Oscillator stabilisation counter used after the deep standby exit.
 Assumes a synchronous start pulse and a released reset from the top.
*/
`timescale 1ns/100ps
module csb_osc_delay (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Control
   input  wire logic start,
   output logic      done
);
   import csb_pkg::*;
   logic [OSC_CNT_W-1:0] cnt;
   logic                 busy;
   wire                  last = (cnt == OSC_CNT_W'(OSC_DELAY_CYC - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt  <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= busy && last;
         if (start) begin
            busy <= 1'b1;
            cnt  <= '0;
         end else if (busy) begin
            busy <= !last;
            cnt  <= cnt + OSC_CNT_W'(1);
         end
      end
   end
endmodule

// >>> testbench/csb_brk_model.sv
/*
 Break module stand-in: raises a break request on command and drops it
 once the core reports the break as taken.
 Assumes the core clock; the bench pulses go for one cycle.
*/
`timescale 1ns/100ps
module csb_brk_model (
   // Clock
   input  wire logic clk,
   // Control
   input  wire logic go,
   input  wire logic taken,
   output logic      brk_req
);
   initial brk_req = 1'b0;
   // Held until taken, so the core's synchroniser never misses it
   always @(posedge clk) begin
      if (taken) begin
         brk_req <= 1'b0;
      end else if (go) begin
         brk_req <= 1'b1;
      end
   end
endmodule

// >>> testbench/tb_csb_core.sv
/*
 Self-checking bench for the standby, break and small-instruction block.
 Assumes the core and its package; the break module is a behavioural model.
*/
`timescale 1ns/100ps
module tb_csb_core;
   import csb_pkg::*;
   logic        clock = 0, arst_n = 0, op_valid = 0, carry_in = 0, irq_req = 0;
   logic        ext_irq = 0, brk_enable = 0, monitor_mode = 0, brk_go = 0;
   logic [7:0]  opcode = 8'h00, operand = 8'h00;
   logic        brk_req, cpu_clk_en, busy, imask, in_break, stacking, vec_fetch;
   logic [15:0] vec_addr, pc, sp, hx;
   int          errors = 0, comparisons = 0, n;

   always #10 clock = ~clock;
   csb_core DUT (.CLOCK(clock), .ARST_N(arst_n), .OP_VALID(op_valid), .OPCODE(opcode), .OPERAND(operand),
      .CARRY_IN(carry_in), .IRQ_REQ(irq_req), .EXT_IRQ(ext_irq), .BRK_ENABLE(brk_enable), .BRK_REQ(brk_req),
      .MONITOR_MODE(monitor_mode), .CPU_CLK_EN(cpu_clk_en), .BUSY(busy), .IMASK(imask), .IN_BREAK(in_break),
      .STACKING(stacking), .VEC_FETCH(vec_fetch), .VEC_ADDR(vec_addr), .PC(pc), .SP(sp), .HX(hx));
   csb_brk_model brk (.clk(clock), .go(brk_go), .taken(in_break), .brk_req(brk_req));

   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      if (errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   task automatic tick;
      @(posedge clock);
      #1;
   endtask
   // Issue one instruction, n counts the busy cycles
   task automatic op(input logic [7:0] o, input logic [7:0] d);
      opcode = o;
      operand = d;
      op_valid = 1;
      tick();
      op_valid = 0;
      n = 0;
      while (busy === 1'b1 && n < 20) begin
         n++;
         tick();
      end
      if (n == 20) begin
         errors++;
         $display("MISMATCH %0t instruction never finished", $time);
      end
   endtask
   task automatic trap(input logic [15:0] vec, input logic mask0);
      int s;
      s = -1;
      n = 0;
      while (vec_fetch !== 1'b1 && n < 40) begin
         if (stacking === 1'b1) begin
            s = n;
            chk(imask, mask0, "mask while stacking");
         end
         n++;
         tick();
      end
      chk(16'(s + 1), 16'(n), "stacking before vector");
      chk(vec_addr, vec, "vector address");
      chk(pc, vec, "pc from vector");
      chk(imask, 1'b1, "mask on entry");
      while (busy === 1'b1 && n < 60) begin
         n++;
         tick();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_adds;
      op(OP_ADD_SP, 8'h80);
      chk(16'(n), 16'(CYC_ADD), "sp add cycles");
      chk(sp, 16'h007f, "sp add negative");
      op(OP_ADD_IX, 8'h7f);
      chk(16'(n), 16'(CYC_ADD), "ix add cycles");
      chk(hx, 16'h007f, "ix add positive");
      op(OP_ADD_IX, 8'hff);
      chk(hx, 16'h007e, "ix add minus one");
      chk(imask, 1'b1, "mask untouched");
   endtask
   task automatic t_branch;
      op(OP_BR_CC, 8'h10);
      chk(16'(n), 16'(CYC_BR), "branch cycles");
      chk(pc, 16'h0010, "branch taken");
      carry_in = 1;
      op(OP_BR_CC, 8'h10);
      chk(pc, 16'h0012, "branch not taken");
      carry_in = 0;
      op(OP_BR_CC, 8'hf0);
      chk(pc, 16'h0004, "branch backward");
   endtask
   task automatic t_break(input logic mon);
      monitor_mode = mon;
      brk_enable = 1;
      brk_go = 1;
      tick();
      brk_go = 0;
      // Request still in the pin filter: the add must run to its end first
      op(OP_ADD_IX, 8'h01);
      chk(16'(n), 16'(CYC_ADD), "add cut by break");
      chk(hx, mon ? 16'h0080 : 16'h007f, "add lost to break");
      trap(mon ? VEC_BRK_MON : VEC_BRK_NORMAL, 1'b1);
      chk(in_break, 1'b1, "in break");
      // Withdrawn request not yet through the filter, so the break persists
      op(OP_RET_TRAP, 8'h00);
      chk(in_break, 1'b1, "break left while requested");
      repeat (4) tick();
      op(OP_RET_TRAP, 8'h00);
      tick();
      chk(in_break, 1'b0, "break ended");
   endtask
   task automatic t_wait;
      op(OP_WAIT, 8'h00);
      chk({imask, cpu_clk_en}, 2'b00, "wait entry");
      ext_irq = 1;
      n = 0;
      while (cpu_clk_en !== 1'b1 && n < 10) begin
         n++;
         tick();
      end
      ext_irq = 0;
      chk({imask, cpu_clk_en}, 2'b01, "wait wake");
      irq_req = 1;
      trap(VEC_BRK_NORMAL, 1'b0);
      op(OP_ADD_SP, 8'h01);
      chk(sp, 16'h0080, "irq ignored while masked");
      irq_req = 0;
   endtask
   task automatic t_stop;
      op(OP_STOP, 8'h00);
      chk({imask, cpu_clk_en}, 2'b00, "stop entry");
      repeat (20) tick();
      chk(cpu_clk_en, 1'b0, "still stopped");
      ext_irq = 1;
      n = 0;
      while (cpu_clk_en !== 1'b1 && n < 400) begin
         n++;
         tick();
      end
      ext_irq = 0;
      chk(16'(n >= OSC_DELAY_CYC && n <= OSC_DELAY_CYC + 8), 1'b1, "oscillator delay");
      chk(imask, 1'b0, "stop wake mask");
      op(OP_WAIT, 8'h00);
      arst_n = 0;
      tick();
      chk({imask, cpu_clk_en}, 2'b11, "reset wake mask");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clock);
      #1 arst_n = 1;
      repeat (3) tick();
      chk(imask, 1'b1, "reset mask");
      chk(sp, SP_RESET, "reset sp");
      t_adds();
      t_branch();
      t_break(1'b0);
      t_break(1'b1);
      t_wait();
      t_stop();
      final_report();
   end
   // Whole run is under a thousand cycles
   initial begin
      #(20 * 5000);
      errors++;
      final_report();
   end
endmodule
